// [hw/ore_alu.sv]
// combinational data path: OR, immediate pass and rotate-left
// assumes operands are stable for the whole cycle they are used
module ore_alu
(
    ore_alu_if.alu alu
);

    always_comb
    begin
        case (alu.op)
            ore_pkg::OP_OR_MEM,
            ore_pkg::OP_UNION_ACCUM_INTO_MEM:
            begin
                alu.result = alu.acc | alu.mem; // RULE1 RULE3
            end
            ore_pkg::OP_OR_IMM:
            begin
                alu.result = alu.acc | alu.imm; // RULE2
            end
            ore_pkg::OP_SUBROUTINE_RETURN_LOAD_IMM:
            begin
                alu.result = alu.imm;
            end
            ore_pkg::OP_ROTATE_LEFT_MEM:
            begin
                alu.result = ore_pkg::rotl8(alu.mem); // RULE8
            end
            default:
            begin
                alu.result = alu.acc;
            end
        endcase
        alu.zero = ore_pkg::is_zero(alu.result); // RULE10
    end

endmodule : ore_alu

// [hw/ore_alu_if.sv]
// carrier between the execution control and its data path
// assumes both ends sit on the same core clock
interface ore_alu_if;
    ore_pkg::ore_op_e  op;
    logic [7:0]        acc;
    logic [7:0]        mem;
    logic [7:0]        imm;
    logic [7:0]        result;
    logic              zero;

    modport exec (output op, output acc, output mem, output imm,
                  input result, input zero);
    modport alu  (input op, input acc, input mem, input imm,
                  output result, output zero);
endinterface : ore_alu_if

// [hw/ore_exec.sv]
// execution control for OR, subroutine/interrupt return and rotate-left
// assumes decode holds op and operands in the cycle valid is high, memory read
// data for the addressed byte arrives in that same cycle, and the stack and
// interrupt controller sit outside on the same clock

// What this block does
// (RULE1) OR memory into accumulator, update zero
// (RULE2) OR immediate into accumulator, update zero
// (RULE3) OR into memory, accumulator kept, zero updated
// (RULE4) return pops stack into program counter
// (RULE5) return with immediate also loads immediate into accumulator
// (RULE6) interrupt return restores counter, sets enable
// (RULE7) pending interrupt is vectored before main resumes
// (RULE8) rotate memory byte left, bit seven wraps
// (RULE9) counter loads take two cycles, dummy inserted
// (RULE10) zero flag reflects OR result only
// (RULE11) each return discards its popped stack entry
module ore_exec
(
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // decoded instruction
    input  wire logic                  instr_valid_in,
    input  wire ore_pkg::ore_op_e      op_in,
    input  wire logic [7:0]            imm_in,
    // data memory
    input  wire logic [7:0]            mem_rdata_in,
    output logic                       mem_we_out,
    output logic [7:0]                 mem_wdata_out,
    // stack
    input  wire logic [12:0]           stack_top_in,
    output logic                       stack_pop_out,
    // program counter
    output logic                       pc_load_out,
    output logic [12:0]                pc_out,
    output logic                       busy_out,
    // interrupt controller
    input  wire logic                  irq_pending_in,
    input  wire logic                  gie_clear_in,
    output logic                       global_interrupt_enable_out,
    output logic                       irq_vector_out,
    // accumulator and status
    output logic [7:0]                 acc_out,
    output logic                       zero_out
);

    typedef struct packed {
        ore_pkg::ore_state_e state;
        logic [7:0]          acc;
        logic                zero;
        logic                gie;
        logic                mem_we;
        logic [7:0]          mem_wdata;
        logic                pc_load;
        logic [12:0]         pc;
        logic                stack_pop;
        logic                irq_vector;
        logic                busy;
    } ore_exec_s;

    ore_exec_s   s_q;
    ore_exec_s   s_d;
    logic        taken;
    ore_alu_if   alu_bus ();

    // an instruction presented during the dummy cycle is not taken
    assign taken = instr_valid_in && (s_q.state == ore_pkg::ST_EXEC);

    assign alu_bus.op  = op_in;
    assign alu_bus.acc = s_q.acc;
    assign alu_bus.mem = mem_rdata_in;
    assign alu_bus.imm = imm_in;

    ore_alu u_alu
    (
        .alu (alu_bus)
    );

    always_comb
    begin
        s_d            = s_q;
        s_d.mem_we     = 1'b0;
        s_d.pc_load    = 1'b0;
        s_d.stack_pop  = 1'b0;
        s_d.irq_vector = 1'b0;
        s_d.busy       = 1'b0;
        // controller clears on interrupt entry; an interrupt return in the same cycle wins
        if (gie_clear_in)
        begin
            s_d.gie = 1'b0;
        end
        case (s_q.state)
            ore_pkg::ST_EXEC:
            begin
                if (taken)
                begin
                    case (op_in)
                        ore_pkg::OP_OR_MEM,
                        ore_pkg::OP_OR_IMM:
                        begin
                            s_d.acc  = alu_bus.result; // RULE1 RULE2
                            s_d.zero = alu_bus.zero;   // RULE10
                        end
                        ore_pkg::OP_UNION_ACCUM_INTO_MEM:
                        begin
                            s_d.mem_we    = 1'b1;           // RULE3
                            s_d.mem_wdata = alu_bus.result;
                            s_d.zero      = alu_bus.zero;   // RULE10
                        end
                        ore_pkg::OP_ROTATE_LEFT_MEM:
                        begin
                            s_d.mem_we    = 1'b1;           // RULE8
                            s_d.mem_wdata = alu_bus.result;
                        end
                        ore_pkg::OP_SUBROUTINE_RETURN,
                        ore_pkg::OP_SUBROUTINE_RETURN_LOAD_IMM,
                        ore_pkg::OP_INTERRUPT_RETURN:
                        begin
                            s_d.pc_load   = 1'b1;           // RULE4
                            s_d.pc        = stack_top_in;
                            s_d.stack_pop = 1'b1;           // RULE11
                            s_d.busy      = 1'b1;           // RULE9
                            s_d.state     = ore_pkg::ST_DUMMY;
                            if (op_in == ore_pkg::OP_SUBROUTINE_RETURN_LOAD_IMM)
                            begin
                                s_d.acc = alu_bus.result;   // RULE5
                            end
                            if (op_in == ore_pkg::OP_INTERRUPT_RETURN)
                            begin
                                s_d.gie        = 1'b1;           // RULE6
                                s_d.irq_vector = irq_pending_in; // RULE7
                            end
                        end
                        default:
                        begin
                            s_d.state = ore_pkg::ST_EXEC;
                        end
                    endcase
                end
            end
            ore_pkg::ST_DUMMY:
            begin
                // the fetch of the new address fills this slot
                s_d.state = ore_pkg::ST_EXEC; // RULE9
            end
            default:
            begin
                s_d.state = ore_pkg::ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s_q.state      <= ore_pkg::ST_EXEC;
            s_q.acc        <= ore_pkg::ACC_RST;
            s_q.zero       <= ore_pkg::ZERO_RST;
            s_q.gie        <= ore_pkg::GIE_RST;
            s_q.mem_we     <= 1'b0;
            s_q.mem_wdata  <= ore_pkg::BYTE_NIL;
            s_q.pc_load    <= 1'b0;
            s_q.pc         <= ore_pkg::PC_RST;
            s_q.stack_pop  <= 1'b0;
            s_q.irq_vector <= 1'b0;
            s_q.busy       <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign acc_out                     = s_q.acc;
    assign zero_out                    = s_q.zero;
    assign global_interrupt_enable_out = s_q.gie;
    assign mem_we_out                  = s_q.mem_we;
    assign mem_wdata_out               = s_q.mem_wdata;
    assign pc_load_out                 = s_q.pc_load;
    assign pc_out                      = s_q.pc;
    assign stack_pop_out               = s_q.stack_pop;
    assign irq_vector_out              = s_q.irq_vector;
    assign busy_out                    = s_q.busy;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_or_mem_acc: assert property ( // RULE1
        taken && op_in == ore_pkg::OP_OR_MEM
        |=> acc_out == ($past(acc_out) | $past(mem_rdata_in)) && !mem_we_out)
        else $error("OR memory into accumulator gave wrong result");

    a_or_imm_acc: assert property ( // RULE2
        taken && op_in == ore_pkg::OP_OR_IMM
        |=> acc_out == ($past(acc_out) | $past(imm_in)))
        else $error("OR immediate into accumulator gave wrong result");

    a_or_into_mem: assert property ( // RULE3
        taken && op_in == ore_pkg::OP_UNION_ACCUM_INTO_MEM
        |=> mem_we_out && $stable(acc_out)
            && mem_wdata_out == ($past(acc_out) | $past(mem_rdata_in))
            && zero_out == ore_pkg::is_zero(mem_wdata_out))
        else $error("OR into memory wrong write or accumulator changed");

    a_return_pc_load: assert property ( // RULE4
        taken && op_in == ore_pkg::OP_SUBROUTINE_RETURN
        |=> pc_load_out && pc_out == $past(stack_top_in)
            && $stable(zero_out) && $stable(acc_out))
        else $error("return did not load counter from stack");

    a_return_imm_acc: assert property ( // RULE5
        taken && op_in == ore_pkg::OP_SUBROUTINE_RETURN_LOAD_IMM
        |=> pc_load_out && acc_out == $past(imm_in) && $stable(zero_out))
        else $error("return with immediate did not load accumulator");

    a_irq_return_gie: assert property ( // RULE6
        taken && op_in == ore_pkg::OP_INTERRUPT_RETURN
        |=> global_interrupt_enable_out && pc_load_out && $stable(zero_out))
        else $error("interrupt return did not set global enable");

    a_irq_return_vector: assert property ( // RULE7
        taken && op_in == ore_pkg::OP_INTERRUPT_RETURN
        |=> irq_vector_out == $past(irq_pending_in))
        else $error("pending interrupt not vectored on return");

    a_rotl_write: assert property ( // RULE8
        taken && op_in == ore_pkg::OP_ROTATE_LEFT_MEM
        |=> mem_we_out && mem_wdata_out == ore_pkg::rotl8($past(mem_rdata_in))
            && $stable(zero_out))
        else $error("rotate left wrote wrong byte");

    a_two_cycle_load: assert property ( // RULE9
        $rose(pc_load_out) |-> busy_out ##1 (!busy_out && !pc_load_out))
        else $error("counter load did not take exactly two cycles");

    a_zero_from_or: assert property ( // RULE10
        taken && (op_in == ore_pkg::OP_OR_MEM || op_in == ore_pkg::OP_OR_IMM)
        |=> zero_out == (acc_out == ore_pkg::BYTE_NIL))
        else $error("zero flag does not match OR result");

    a_single_pop: assert property ( // RULE11
        stack_pop_out |-> pc_load_out ##1 !stack_pop_out)
        else $error("stack popped more than once per return");

    c_sub_return: cover property (taken && op_in == ore_pkg::OP_SUBROUTINE_RETURN);
    c_irq_return_pending: cover property (
        taken && op_in == ore_pkg::OP_INTERRUPT_RETURN && irq_pending_in);
    c_or_into_mem_zero: cover property (mem_we_out && zero_out);
    c_or_back_to_back: cover property (
        (taken && op_in == ore_pkg::OP_OR_IMM) ##1 (taken && op_in == ore_pkg::OP_OR_MEM));

endmodule : ore_exec

// [hw/ore_pkg.sv]
// shared types and constants for the OR / return / rotate execution slice
// assumes one core clock; decode supplies one operation code per instruction
package ore_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned PC_W   = 13;

    // reset values
    localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
    localparam logic              ZERO_RST = 1'b0;
    localparam logic              GIE_RST  = 1'b0;
    localparam logic [PC_W-1:0]   PC_RST   = 13'h0000;
    localparam logic [DATA_W-1:0] BYTE_NIL = 8'h00;

    // cycles an instruction that loads the program counter occupies
    localparam int unsigned PC_LOAD_CYCLES = 2;

    typedef enum logic [2:0] {
        OP_OTHER,
        OP_OR_MEM,
        OP_OR_IMM,
        OP_UNION_ACCUM_INTO_MEM,
        OP_SUBROUTINE_RETURN,
        OP_SUBROUTINE_RETURN_LOAD_IMM,
        OP_INTERRUPT_RETURN,
        OP_ROTATE_LEFT_MEM
    } ore_op_e;

    typedef enum logic {
        ST_EXEC,
        ST_DUMMY
    } ore_state_e;

    function automatic logic [DATA_W-1:0] rotl8(input logic [DATA_W-1:0] v);
        rotl8 = {v[DATA_W-2:0], v[DATA_W-1]};
    endfunction : rotl8

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == BYTE_NIL);
    endfunction : is_zero

endpackage : ore_pkg

// [sim/tb_top.sv]
// self-checking bench for the OR / return / rotate execution slice
// assumes ore_exec is the top; bench stands in for decode, memory, stack and irq control
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    `define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

    logic                  clk_in;
    logic                  rst_in;
    logic                  instr_valid_in;
    ore_pkg::ore_op_e      op_in;
    logic [7:0]            imm_in;
    logic [7:0]            mem_rdata_in;
    logic                  mem_we_out;
    logic [7:0]            mem_wdata_out;
    logic [12:0]           stack_top_in;
    logic                  stack_pop_out;
    logic                  pc_load_out;
    logic [12:0]           pc_out;
    logic                  busy_out;
    logic                  irq_pending_in;
    logic                  gie_clear_in;
    logic                  global_interrupt_enable_out;
    logic                  irq_vector_out;
    logic [7:0]            acc_out;
    logic                  zero_out;

    int                    bad_count;
    int                    samples_checked;
    int                    seed;
    logic [7:0]            acc_m;
    logic                  zero_m;
    logic                  gie_m;

    ore_exec u_ore_exec (
        .clk_in(clk_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in), .op_in(op_in),
        .imm_in(imm_in), .mem_rdata_in(mem_rdata_in), .mem_we_out(mem_we_out),
        .mem_wdata_out(mem_wdata_out), .stack_top_in(stack_top_in),
        .stack_pop_out(stack_pop_out), .pc_load_out(pc_load_out), .pc_out(pc_out),
        .busy_out(busy_out), .irq_pending_in(irq_pending_in), .gie_clear_in(gie_clear_in),
        .global_interrupt_enable_out(global_interrupt_enable_out),
        .irq_vector_out(irq_vector_out), .acc_out(acc_out), .zero_out(zero_out)
    );

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // written bit by bit so it does not share the design's helper
    function automatic logic [7:0] exp_rotl(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 7; i++) r[i+1] = v[i];
        r[0] = v[7];
        return r;
    endfunction : exp_rotl

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    // caller stands 1 ns after a rising edge; returns there again
    task automatic do_op(input ore_pkg::ore_op_e op, input logic [7:0] im, input logic [7:0] md,
                         input logic [12:0] st, input logic ip, input logic gc, input logic vld);
        logic pc_ld_e;
        logic we_e;
        logic [7:0] wd_e;
        logic z_e;
        instr_valid_in = vld;
        op_in          = op;
        imm_in         = im;
        mem_rdata_in   = md;
        stack_top_in   = st;
        irq_pending_in = ip;
        gie_clear_in   = gc;
        pc_ld_e = vld && (op inside {ore_pkg::OP_SUBROUTINE_RETURN,
                          ore_pkg::OP_SUBROUTINE_RETURN_LOAD_IMM, ore_pkg::OP_INTERRUPT_RETURN});
        we_e = vld && (op inside {ore_pkg::OP_UNION_ACCUM_INTO_MEM, ore_pkg::OP_ROTATE_LEFT_MEM});
        wd_e = (op == ore_pkg::OP_ROTATE_LEFT_MEM) ? exp_rotl(md) : (acc_m | md);
        z_e  = zero_m;
        if (vld && op == ore_pkg::OP_OR_MEM) acc_m = acc_m | md;
        if (vld && op == ore_pkg::OP_OR_IMM) acc_m = acc_m | im;
        if (vld && op inside {ore_pkg::OP_OR_MEM, ore_pkg::OP_OR_IMM}) z_e = (acc_m == 8'h00);
        if (vld && op == ore_pkg::OP_UNION_ACCUM_INTO_MEM) z_e = ((acc_m | md) == 8'h00);
        if (vld && op == ore_pkg::OP_SUBROUTINE_RETURN_LOAD_IMM) acc_m = im;
        if (vld && op == ore_pkg::OP_INTERRUPT_RETURN) gie_m = 1'b1;
        else if (gc) gie_m = 1'b0;
        zero_m = z_e;
        @(posedge clk_in);
        #1;
        `CHK(acc_out, acc_m)
        `CHK(zero_out, zero_m)
        `CHK(mem_we_out, we_e)
        if (we_e) `CHK(mem_wdata_out, wd_e)
        `CHK(global_interrupt_enable_out, gie_m)
        `CHK(pc_load_out, pc_ld_e)
        `CHK(stack_pop_out, pc_ld_e)
        `CHK(busy_out, pc_ld_e)
        `CHK(irq_vector_out, pc_ld_e && ip && op == ore_pkg::OP_INTERRUPT_RETURN)
        if (pc_ld_e) `CHK(pc_out, st)
        if (pc_ld_e)
        begin
            // offered in the dummy cycle, so it must be dropped
            instr_valid_in = 1'b1;
            op_in          = ore_pkg::OP_OR_IMM;
            imm_in         = 8'hFF;
            gie_clear_in   = 1'b0;
            @(posedge clk_in);
            #1;
            `CHK(busy_out, 1'b0)
            `CHK(pc_load_out, 1'b0)
            `CHK(stack_pop_out, 1'b0)
            `CHK(acc_out, acc_m)
        end
    endtask : do_op

    initial
    begin
        bad_count       = 0;
        samples_checked = 0;
        seed            = 94;
        rst_in          = 1'b1;
        instr_valid_in  = 1'b0;
        op_in           = ore_pkg::OP_OTHER;
        imm_in          = 8'h00;
        mem_rdata_in    = 8'h00;
        stack_top_in    = 13'h0000;
        irq_pending_in  = 1'b0;
        gie_clear_in    = 1'b0;
        acc_m           = 8'h00;
        zero_m          = 1'b0;
        gie_m           = 1'b0;
        repeat (12) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        `CHK(acc_out, 8'h00)
        `CHK(pc_out, 13'h0000)
        `CHK(global_interrupt_enable_out, 1'b0)
        $display("test reset done");
        // zero result, rotate wrap, nested returns, pending interrupt on return
        do_op(ore_pkg::OP_OR_MEM, 8'h00, 8'h00, 13'h0000, 1'b0, 1'b0, 1'b1);
        do_op(ore_pkg::OP_ROTATE_LEFT_MEM, 8'h00, 8'h80, 13'h0000, 1'b0, 1'b0, 1'b1);
        do_op(ore_pkg::OP_UNION_ACCUM_INTO_MEM, 8'h00, 8'h00, 13'h0, 1'b0, 1'b0, 1'b1);
        do_op(ore_pkg::OP_OR_IMM, 8'hA5, 8'h00, 13'h0000, 1'b0, 1'b0, 1'b1);
        do_op(ore_pkg::OP_UNION_ACCUM_INTO_MEM, 8'h00, 8'h5A, 13'h0, 1'b0, 1'b0, 1'b1);
        do_op(ore_pkg::OP_SUBROUTINE_RETURN, 8'h00, 8'h00, 13'h1FFF, 1'b0, 1'b0, 1'b1);
        do_op(ore_pkg::OP_SUBROUTINE_RETURN_LOAD_IMM, 8'h00, 8'h00, 13'h0123, 1'b0, 1'b0,
              1'b1);
        do_op(ore_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00, 13'h0AAA, 1'b1, 1'b1, 1'b1);
        do_op(ore_pkg::OP_OTHER, 8'hFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 1'b1);
        do_op(ore_pkg::OP_INTERRUPT_RETURN, 8'h00, 8'h00, 13'h1555, 1'b0, 1'b0, 1'b1);
        $display("test corners done");
        for (int n = 0; n < 400; n++)
        begin
            do_op(ore_pkg::ore_op_e'($random(seed) & 7), 8'($random(seed)), 8'($random(seed)),
                  13'($random(seed)), 1'($random(seed)), ($random(seed) & 7) == 0,
                  ($random(seed) & 3) != 0);
        end
        $display("test random done");
        // second reset lands in the dummy cycle of an interrupt return
        instr_valid_in = 1'h1;
        op_in          = ore_pkg::OP_INTERRUPT_RETURN;
        @(posedge clk_in);
        #1;
        rst_in         = 1'h1;
        instr_valid_in = 1'h0;
        #1;
        `CHK(busy_out, 1'h0)
        `CHK(pc_load_out, 1'h0)
        `CHK(stack_pop_out, 1'h0)
        `CHK(global_interrupt_enable_out, 1'h0)
        `CHK(acc_out, 8'h00)
        `CHK(zero_out, 1'h0)
        repeat (2) @(posedge clk_in);
        #1;
        rst_in = 1'h0;
        acc_m  = 8'h00;
        zero_m = 1'h0;
        gie_m  = 1'h0;
        do_op(ore_pkg::OP_OR_IMM, 8'h00, 8'h00, 13'h0000, 1'h0, 1'h0, 1'h1);
        do_op(ore_pkg::OP_SUBROUTINE_RETURN, 8'h00, 8'h00, 13'h0F0F, 1'h0, 1'h0, 1'h1);
        $display("test second reset done");
        report_and_stop();
    end

    initial
    begin
        #2000000;
        bad_count++;
        report_and_stop();
    end
endmodule : tb_top
